// >>> logic/pfcfs_cfg.svh
`ifndef PFCFS_CFG_SVH
`define PFCFS_CFG_SVH

// Clock rate and the microsecond enable derived from it.
`define PFCFS_CLK_MHZ        40
`define PFCFS_US_DIV         (`PFCFS_CLK_MHZ)

// Fault pin filter time in microseconds and its cycle count.
`define PFCFS_FILT_US        30
`define PFCFS_FILT_CYC       (`PFCFS_FILT_US * `PFCFS_CLK_MHZ)

// Timer defaults in microseconds; PFCFS_GOOD_TOGGLES is a count of toggles.
`define PFCFS_OTP_BLANK_US   5000
`define PFCFS_SAG_BLANK_US   20000
`define PFCFS_BO_BLANK_US    50000
`define PFCFS_SOFT_STOP_US   2000
`define PFCFS_SOFT_OVP_US    1000
`define PFCFS_LFREQ_DLY_US   100000
`define PFCFS_BUV_US         200000
`define PFCFS_HALF_MIN_US    7692
`define PFCFS_HALF_MAX_US    11111
`define PFCFS_GOOD_TOGGLES   4

// Register byte offsets.
`define PFCFS_ADR_CTRL       8'h00
`define PFCFS_ADR_FAULT      8'h04
`define PFCFS_ADR_IRQ_STAT   8'h08
`define PFCFS_ADR_IRQ_MASK   8'h0C

// Reset values.
`define PFCFS_CTRL_RST       1'h1
`define PFCFS_MASK_RST       9'h000

`endif

// >>> logic/pfcfs_pkg.sv
package pfcfs_pkg;

    // Comparator and line flags from the analog front end.
    typedef struct packed {
        logic fltAboveOvp;
        logic fltBelowOtp;
        logic fltAboveRec;
        logic lineBelowStop;
        logic lineAboveStart;
        logic linePolarity;
        logic fbBelowUvp;
        logic fbAboveUvpHys;
        logic fbBelowBuv;
        logic fbAboveSoftOvp;
        logic fbAboveHardOvp;
        logic fbBelowOvpRec;
        logic fbAboveReg;
        logic static_overvoltage;
    } pfcfs_cmp_type;

    // Live fault vector, also the layout of the interrupt registers.
    typedef struct packed {
        logic hardOvp;
        logic softOvp;
        logic bulk_undervoltage_fault;
        logic feedback_undervoltage_fault;
        logic lineFreq;
        logic bo;
        logic sag;
        logic otp;
        logic ovpLatch;
    } pfcfs_flt_type;

    // Line sag sequence, one-hot.
    typedef enum logic [2:0] {
        SAG_IDLE    = 3'b001,
        SAG_SOFT    = 3'b010,
        SAG_STOPPED = 3'b100
    } pfcfs_sag_type;

endpackage : pfcfs_pkg

// >>> logic/pfcfs_sync.sv
`timescale 1ns/10ps

// Three-stage synchroniser; a change passes once stages two and three agree.
module pfcfs_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset.
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    // Asynchronous input and qualified output.
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_r;  // First stage, read only by the second.
    logic [W-1:0] s2_r;  // Second stage.
    logic [W-1:0] s3_r;  // Third stage.

    // Bits where the last two stages agree take the new value; the rest hold.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            dout <= '0;
        end
        else
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dout <= (s2_r & s3_r) | (dout & (s2_r | s3_r));
        end
    end

endmodule : pfcfs_sync

// >>> logic/pfcfs_persist_filter.sv
`timescale 1ns/10ps

// Declares a hit once the level has stood longer than LIMIT cycles.
module pfcfs_persist_filter #(
    parameter int unsigned LIMIT = 1200
) (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic resetn,
    // Condition and filtered result.
    input  wire logic level,
    output logic      hit
);
    localparam int unsigned CW = $clog2(LIMIT + 2);
    localparam logic [CW-1:0] LIM = CW'(LIMIT);

    logic [CW-1:0] cnt_r;  // Cycles the level has been continuously high.

    // Any drop of the level restarts the count, so noise never accumulates.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_r <= '0;
            hit   <= 1'b0;
        end
        else
        begin
            cnt_r <= !level ? '0 : (cnt_r == LIM ? cnt_r : cnt_r + 1'b1);
            hit   <= level && (cnt_r == LIM);
        end
    end

endmodule : pfcfs_persist_filter

// >>> logic/pfcfs_fault_supervisor.sv
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`include "pfcfs_cfg.svh"

// Contract
// - Upper fault pin trip latches drives off.
// - Lower fault pin trip stops switching, overtemperature.
// - Between thresholds no fault pin fault.
// - Overtemperature clears itself above recovery threshold.
// - Overtemperature blanked for interval after power-up.
// - Both fault pin conditions need persistent filtering.
// - Line sag: soft stop, then drives off.
// - Brownout resets controller, polarity off.
// - Bad line period stops rectifiers, then more.
// - Feedback undervoltage disables drives with hysteresis.
// - Bulk undervoltage stops drives, restarts on timer.
// - Soft overvoltage sequence then PWM off.
// - Hard overvoltage stops PWM at once.
// - Downstream-ok held low until regulation reached.
module pfcfs_fault_supervisor #(
    parameter int unsigned OTP_BLANK_US = `PFCFS_OTP_BLANK_US,
    parameter int unsigned SAG_BLANK_US = `PFCFS_SAG_BLANK_US,
    parameter int unsigned BO_BLANK_US  = `PFCFS_BO_BLANK_US,
    parameter int unsigned SOFT_STOP_US = `PFCFS_SOFT_STOP_US,
    parameter int unsigned SOFT_OVP_US  = `PFCFS_SOFT_OVP_US,
    parameter int unsigned LFREQ_DLY_US = `PFCFS_LFREQ_DLY_US,
    parameter int unsigned BUV_US       = `PFCFS_BUV_US,
    parameter int unsigned HALF_MIN_US  = `PFCFS_HALF_MIN_US,
    parameter int unsigned HALF_MAX_US  = `PFCFS_HALF_MAX_US
) (
    // Clock and master reset.
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    // Comparator flags, asynchronous to sys_clk.
    input  wire pfcfs_pkg::pfcfs_cmp_type cmpRaw,
    // Wishbone classic slave.
    input  wire logic                   wbCyc,
    input  wire logic                   wbStb,
    input  wire logic                   wbWe,
    input  wire logic [7:0]             wbAdr,
    input  wire logic [3:0]             wbSel,
    input  wire logic [31:0]            wbDatW,
    output logic                        wbAck,
    output logic [31:0]                 wbDatR,
    // Drive gating and status.
    output logic                        pwmEnable,
    output logic                        srEnable,
    output logic                        polarityEnable,
    output logic                        downstreamOk,
    output logic                        skipAllowed,
    output logic                        controllerReset,
    output logic                        irq
);
    localparam logic [23:0] T_BLANK = 24'(OTP_BLANK_US);
    localparam logic [23:0] T_SAG   = 24'(SAG_BLANK_US);
    localparam logic [23:0] T_BO    = 24'(BO_BLANK_US);
    localparam logic [23:0] T_SOFT  = 24'(SOFT_STOP_US);
    localparam logic [23:0] T_SOVP  = 24'(SOFT_OVP_US);
    localparam logic [23:0] T_LFDLY = 24'(LFREQ_DLY_US);
    localparam logic [23:0] BULK_FAULT_RESTART_TIMER   = 24'(BUV_US);
    localparam logic [23:0] T_HMIN  = 24'(HALF_MIN_US);
    localparam logic [23:0] T_HMAX  = 24'(HALF_MAX_US);
    localparam logic [5:0]  US_LAST = 6'(`PFCFS_US_DIV - 1);
    localparam logic [2:0]  GOOD_LAST = 3'(`PFCFS_GOOD_TOGGLES - 1);

    pfcfs_pkg::pfcfs_cmp_type cmp;       // Qualified comparator flags.
    logic                     ovpFilt;   // Upper threshold held past filter.
    logic                     otpFilt;   // Lower threshold held past filter.

    // All flags cross into sys_clk through one synchroniser bank.
    pfcfs_sync #(.W($bits(pfcfs_pkg::pfcfs_cmp_type))) uSync (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .din     (cmpRaw),
        .dout    (cmp)
    );

    // Fault pin detectors only trip on the extremes, never inside the band.
    pfcfs_persist_filter #(.LIMIT(`PFCFS_FILT_CYC)) uOvpFilt (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .level   (cmp.fltAboveOvp),
        .hit     (ovpFilt)
    );
    pfcfs_persist_filter #(.LIMIT(`PFCFS_FILT_CYC)) uOtpFilt (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .level   (cmp.fltBelowOtp),
        .hit     (otpFilt)
    );

    logic [5:0]  divCnt_r;      // Microsecond divider.
    logic        usTick_r;      // One-cycle microsecond enable.
    logic [23:0] blankCnt_r;    // Power-up blanking counter.
    logic [23:0] lowCnt_r;      // Time the line has been below stop.
    logic [23:0] softCnt_r;     // Soft stop progress.
    logic [23:0] halfCnt_r;     // Time since last polarity toggle.
    logic [23:0] lfDlyCnt_r;    // Line period fault delay.
    logic [23:0] sovpCnt_r;     // Soft overvoltage sequence progress.
    logic [23:0] buvCnt_r;      // Bulk fault restart timer.
    logic [2:0]  goodCnt_r;     // Consecutive in-window toggles.
    logic        polPrev_r;     // Previous line polarity.
    logic        ovpLatch_r;    // Fault pin overvoltage latch.
    logic        otp_r;         // Overtemperature fault.
    logic        bo_r;          // Brownout fault.
    logic        lf1_r;         // Line period out of window.
    logic        lf2_r;         // Line period fault after delay.
    logic        uvp_r;         // Feedback undervoltage.
    logic        buv_r;         // Bulk undervoltage.
    logic        softOvp_r;     // Soft overvoltage.
    logic        hardOvp_r;     // Hard overvoltage.
    logic        regFlag_r;     // Internal downstream-ok flag.
    logic        ctrlEn_r;      // Software drive enable.
    pfcfs_pkg::pfcfs_sag_type sagState_r;  // Line sag sequence.
    pfcfs_pkg::pfcfs_flt_type fltPrev_r;   // Fault vector last cycle.
    pfcfs_pkg::pfcfs_flt_type irqStat_r;   // Sticky fault events.
    pfcfs_pkg::pfcfs_flt_type irqMask_r;   // Interrupt mask.

    // Decoded conditions.
    wire blankDone = (blankCnt_r == T_BLANK);
    wire sagSet    = cmp.lineBelowStop && (lowCnt_r >= T_SAG);
    wire boSet     = cmp.lineBelowStop && (lowCnt_r >= T_BO);
    wire sagActive = (sagState_r != pfcfs_pkg::SAG_IDLE);
    wire sagOff    = (sagState_r == pfcfs_pkg::SAG_STOPPED);
    wire polToggle = (cmp.linePolarity != polPrev_r);
    wire inWindow  = (halfCnt_r >= T_HMIN) && (halfCnt_r <= T_HMAX);
    wire goodTog   = polToggle && inWindow;
    wire badLine   = (polToggle && !inWindow) || (halfCnt_r > T_HMAX);
    wire sovpOff   = softOvp_r && (sovpCnt_r == T_SOVP);
    wire buvDone   = buv_r && (buvCnt_r == BULK_FAULT_RESTART_TIMER);

    // Microsecond enable; every slow timer advances on it.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            divCnt_r <= 6'h00;
            usTick_r <= 1'b0;
        end
        else
        begin
            divCnt_r <= (divCnt_r == US_LAST) ? 6'h00 : divCnt_r + 6'h01;
            usTick_r <= (divCnt_r == US_LAST);
        end
    end

    // Timers. All but softCnt_r and buvCnt_r saturate, so that a long fault never wraps to a false pass.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            blankCnt_r <= 24'h00_0000;
            lowCnt_r   <= 24'h00_0000;
            softCnt_r  <= 24'h00_0000;
            halfCnt_r  <= 24'h00_0000;
            lfDlyCnt_r <= 24'h00_0000;
            sovpCnt_r  <= 24'h00_0000;
            buvCnt_r   <= 24'h00_0000;
        end
        else
        begin
            if (usTick_r && !blankDone)
                blankCnt_r <= blankCnt_r + 24'h00_0001;
            if (!cmp.lineBelowStop)
                lowCnt_r <= 24'h00_0000;
            else if (usTick_r && lowCnt_r != 24'hFF_FFFF)
                lowCnt_r <= lowCnt_r + 24'h00_0001;
            if (sagState_r != pfcfs_pkg::SAG_SOFT)
                softCnt_r <= 24'h00_0000;
            else if (usTick_r)
                softCnt_r <= softCnt_r + 24'h00_0001;
            if (polToggle)
                halfCnt_r <= 24'h00_0000;
            else if (usTick_r && halfCnt_r != 24'hFF_FFFF)
                halfCnt_r <= halfCnt_r + 24'h00_0001;
            if (!lf1_r)
                lfDlyCnt_r <= 24'h00_0000;
            else if (usTick_r && lfDlyCnt_r != T_LFDLY)
                lfDlyCnt_r <= lfDlyCnt_r + 24'h00_0001;
            if (!softOvp_r)
                sovpCnt_r <= 24'h00_0000;
            else if (usTick_r && !sovpOff)
                sovpCnt_r <= sovpCnt_r + 24'h00_0001;
            // A line sag cancels the bulk restart timer.
            if (!buv_r || sagActive || buvDone)
                buvCnt_r <= 24'h00_0000;
            else if (usTick_r)
                buvCnt_r <= buvCnt_r + 24'h00_0001;
        end
    end

    // Line sag sequence: soft stop first, drives off once it ends.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            sagState_r <= pfcfs_pkg::SAG_IDLE;
        else if (cmp.lineAboveStart)
            sagState_r <= pfcfs_pkg::SAG_IDLE;
        else
        begin
            case (sagState_r)
                pfcfs_pkg::SAG_IDLE:
                    if (sagSet)
                        sagState_r <= pfcfs_pkg::SAG_SOFT;
                pfcfs_pkg::SAG_SOFT:
                    if (softCnt_r == T_SOFT)
                        sagState_r <= pfcfs_pkg::SAG_STOPPED;
                default:
                    sagState_r <= pfcfs_pkg::SAG_STOPPED;
            endcase
        end
    end

    // Fault pin faults. The overvoltage latch only leaves on master reset.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ovpLatch_r <= 1'b0;
            otp_r      <= 1'b0;
        end
        else
        begin
            if (ovpFilt)
                ovpLatch_r <= 1'b1;
            if (otpFilt && blankDone)
                otp_r <= 1'b1;
            else if (cmp.fltAboveRec)
                otp_r <= 1'b0;
        end
    end

    // Line and feedback faults.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            bo_r      <= 1'b0;
            lf1_r     <= 1'b0;
            lf2_r     <= 1'b0;
            goodCnt_r <= 3'h0;
            polPrev_r <= 1'b0;
            uvp_r     <= 1'b0;
            buv_r     <= 1'b0;
            softOvp_r <= 1'b0;
            hardOvp_r <= 1'b0;
            regFlag_r <= 1'b0;
        end
        else
        begin
            polPrev_r <= cmp.linePolarity;
            if (boSet)
                bo_r <= 1'b1;
            else if (cmp.lineAboveStart)
                bo_r <= 1'b0;
            // Four toggles in a row inside the window clear both stages.
            if (badLine)
            begin
                lf1_r     <= 1'b1;
                goodCnt_r <= 3'h0;
            end
            else if (goodTog && lf1_r)
            begin
                if (goodCnt_r == GOOD_LAST)
                begin
                    lf1_r     <= 1'b0;
                    goodCnt_r <= 3'h0;
                end
                else
                    goodCnt_r <= goodCnt_r + 3'h1;
            end
            if (!lf1_r)
                lf2_r <= 1'b0;
            else if (lfDlyCnt_r == T_LFDLY)
                lf2_r <= 1'b1;
            if (cmp.fbBelowUvp)
                uvp_r <= 1'b1;
            else if (cmp.fbAboveUvpHys)
                uvp_r <= 1'b0;
            if (buvDone)
                buv_r <= 1'b0;
            else if (regFlag_r && cmp.fbBelowBuv)
                buv_r <= 1'b1;
            if (cmp.fbAboveSoftOvp)
                softOvp_r <= 1'b1;
            else if (cmp.fbBelowOvpRec)
                softOvp_r <= 1'b0;
            if (cmp.fbAboveHardOvp)
                hardOvp_r <= 1'b1;
            else if (cmp.fbBelowOvpRec)
                hardOvp_r <= 1'b0;
            if (cmp.fbAboveReg)
                regFlag_r <= 1'b1;
        end
    end

    // Drive gating. Each fault removes exactly the drives it must.
    wire driveBase = ctrlEn_r && regFlag_r && !ovpLatch_r && !otp_r && !bo_r
                     && !uvp_r && !buv_r && !sagOff;
    wire pwmNxt    = driveBase && !lf2_r && !sovpOff && !hardOvp_r;
    wire srNxt     = driveBase && !lf1_r;
    wire okNxt     = regFlag_r && !ovpLatch_r && !otp_r && !lf2_r && !uvp_r
                     && !buv_r && !(sagActive && cmp.static_overvoltage)
                     && !(bo_r && cmp.static_overvoltage);

    // Outputs leave from flip-flops.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pwmEnable       <= 1'b0;
            srEnable        <= 1'b0;
            polarityEnable  <= 1'b0;
            downstreamOk    <= 1'b0;
            skipAllowed     <= 1'b0;
            controllerReset <= 1'b0;
        end
        else
        begin
            pwmEnable       <= pwmNxt;
            srEnable        <= srNxt;
            polarityEnable  <= !bo_r;
            downstreamOk    <= okNxt;
            skipAllowed     <= regFlag_r;
            controllerReset <= bo_r;
        end
    end

    // Fault vector and its rising edges as interrupt events.
    pfcfs_pkg::pfcfs_flt_type flt;
    assign flt = '{hardOvp: hardOvp_r, softOvp: softOvp_r, bulk_undervoltage_fault: buv_r, feedback_undervoltage_fault: uvp_r,
                   lineFreq: lf1_r, bo: bo_r, sag: sagActive, otp: otp_r,
                   ovpLatch: ovpLatch_r};
    wire [8:0]  fltEvt  = flt & ~fltPrev_r;

    // Bus decode; the slave answers one cycle after the strobe.
    wire        busHit  = wbCyc && wbStb && !wbAck;
    wire        busWr   = busHit && wbWe;
    wire        selCtrl = (wbAdr == `PFCFS_ADR_CTRL);
    wire        selFlt  = (wbAdr == `PFCFS_ADR_FAULT);
    wire        selStat = (wbAdr == `PFCFS_ADR_IRQ_STAT);
    wire        selMask = (wbAdr == `PFCFS_ADR_IRQ_MASK);
    wire [8:0]  laneMsk = {wbSel[1], {8{wbSel[0]}}};
    wire [8:0]  wrBits  = wbDatW[8:0] & laneMsk;
    wire [8:0]  statClr = (busWr && selStat) ? wrBits : 9'h000;
    wire [8:0]  statNxt = (irqStat_r & ~statClr) | fltEvt;
    wire [8:0]  maskNxt = (busWr && selMask) ? ((irqMask_r & ~laneMsk) | wrBits)
                                               : irqMask_r;
    wire [31:0] rdMux   = selCtrl ? {31'h0000_0000, ctrlEn_r}
                        : selFlt  ? {23'h00_0000, flt}
                        : selStat ? {23'h00_0000, irqStat_r}
                        : selMask ? {23'h00_0000, irqMask_r}
                        : 32'h0000_0000;

    // Register file. A new event wins over a write-one-to-clear.
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrlEn_r  <= `PFCFS_CTRL_RST;
            fltPrev_r <= '0;
            irqStat_r <= '0;
            irqMask_r <= `PFCFS_MASK_RST;
            wbAck     <= 1'b0;
            wbDatR    <= 32'h0000_0000;
            irq       <= 1'b0;
        end
        else
        begin
            if (busWr && selCtrl && wbSel[0])
                ctrlEn_r <= wbDatW[0];
            fltPrev_r <= flt;
            irqStat_r <= statNxt;
            irqMask_r <= maskNxt;
            wbAck     <= busHit;
            if (busHit)
                wbDatR <= rdMux;
            irq       <= |(statNxt & maskNxt);
        end
    end

    // Checks on the design's own behaviour.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence seqLatched;
        ovpLatch_r ##1 (!pwmEnable && !srEnable && !downstreamOk);
    endsequence

    sequence seqSagDone;
        (sagState_r == pfcfs_pkg::SAG_STOPPED && !cmp.lineAboveStart) ##1 1'b1;
    endsequence

    AST_OVP_LATCH: assert property (ovpLatch_r |-> seqLatched ##0 ovpLatch_r)
        else $error("Latched fault did not hold drives off.");
    AST_OTP_OFF: assert property (otp_r |=> !pwmEnable && !srEnable && !downstreamOk)
        else $error("Overtemperature left a drive on.");
    AST_OTP_REC: assert property (otp_r && !otpFilt && cmp.fltAboveRec |=> !otp_r)
        else $error("Overtemperature did not recover.");
    AST_OTP_BLANK: assert property (!blankDone |-> !otp_r)
        else $error("Overtemperature raised during blanking.");
    AST_FILTER: assert property ($rose(ovpLatch_r) |-> $past(cmp.fltAboveOvp, 2))
        else $error("Latch set without a persistent condition.");
    AST_SAG_OFF: assert property (seqSagDone |-> !pwmEnable && !srEnable)
        else $error("Drives on after soft stop ended.");
    AST_BO_POL: assert property (bo_r |=> !polarityEnable && controllerReset)
        else $error("Brownout left polarity active.");
    AST_LF_SR: assert property (lf1_r |=> !srEnable)
        else $error("Rectifier driven with bad line period.");
    AST_UVP: assert property (uvp_r && !bo_r |=> !pwmEnable && polarityEnable)
        else $error("Undervoltage handling wrong.");
    AST_BUV_SET: assert property ($rose(buv_r) |-> $past(regFlag_r))
        else $error("Bulk fault set before regulation.");
    AST_HARD_OVP: assert property (hardOvp_r |=> !pwmEnable)
        else $error("PWM on under hard overvoltage.");
    AST_REG_OK: assert property (!regFlag_r |=> !downstreamOk && !skipAllowed)
        else $error("Downstream ok before regulation.");
    AST_ACK: assert property (wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
        else $error("Bus answer not a single cycle.");

endmodule : pfcfs_fault_supervisor

// >>> sim/pfcfs_front_model.sv
`timescale 1ns/10ps

// Line polarity source of a steady mains, toggling every HALF cycles.
module pfcfs_front_model #(
    parameter int unsigned HALF = 240
) (
    // Clock and polarity flag.
    input  wire logic sys_clk,
    output logic      linePol
);
    int unsigned cnt = 0; // Cycles into the current half period.

    // Half period stays in the line window, so toggles count as good.
    always @(posedge sys_clk)
    begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1)
            linePol <= ~linePol;
    end

    initial linePol = 1'b0;
endmodule : pfcfs_front_model

// >>> sim/tb_top.sv
`timescale 1ns/10ps

module tb_top;
    logic                     sys_clk, resetn, linePol, wbCyc, wbStb, wbWe, wbAck;
    logic                     pwm, sr, pol, ok, skip, crst, irq;
    logic [3:0]               wbSel;
    logic [7:0]               wbAdr;
    logic [31:0]              wbDatW, wbDatR;
    pfcfs_pkg::pfcfs_cmp_type cmp;
    logic [38:0]              expQ[$]; // Expected {irq,pwm,sr,pol,ok,skip,crst,data}.
    int                       error_cnt = 0;
    int                       samples_checked = 0;

    // Short timers; the 30 us pin filter stays at 1200 cycles.
    pfcfs_fault_supervisor #(.OTP_BLANK_US(5), .SAG_BLANK_US(2), .BO_BLANK_US(6),
        .SOFT_STOP_US(3), .SOFT_OVP_US(3), .LFREQ_DLY_US(10), .BUV_US(10),
        .HALF_MIN_US(4), .HALF_MAX_US(8)) dut_u (.sys_clk(sys_clk), .resetn(resetn),
        .cmpRaw({cmp[13:9], linePol, cmp[7:0]}), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbAck(wbAck),
        .wbDatR(wbDatR), .pwmEnable(pwm), .srEnable(sr), .polarityEnable(pol),
        .downstreamOk(ok), .skipAllowed(skip), .controllerReset(crst), .irq(irq));
    pfcfs_front_model #(.HALF(240)) front_u (.sys_clk(sys_clk), .linePol(linePol));

    task automatic chk(input logic [38:0] seen, input logic [38:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : w

    // One classic cycle; a read notes its expected outputs first.
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                       input logic [6:0] o);
        if (!we)
            expQ.push_back({o, d});
        @(posedge sys_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatW <= d;
        // Only the watchdog ends a wait for the answer.
        do
            @(posedge sys_clk);
        while (wbAck !== 1'b1);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask : bus

    // Monitor takes the oldest note at each read answer.
    always @(posedge sys_clk)
        if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0)
            chk({irq, pwm, sr, pol, ok, skip, crst, wbDatR}, expQ.pop_front());

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // The watchdog allows about three and a half times the expected run.
    initial
    begin
        #(25 * 30000);
        error_cnt++;
        test_done();
    end

    initial
    begin
        resetn = 1'b0;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbSel = 4'h3;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbDatW = 32'h0000_0000;
        cmp = 14'h0A46;
        void'($urandom(57921));
        w(10);
        resetn <= 1'b1;
        w(2000);
        bus(0, 8'h00, 32'h0000_0001, 7'h3E);
        bus(0, 8'h0C, 32'h0000_0000, 7'h3E);
        // A write with no lane selected must leave the mask alone.
        wbSel <= 4'h0;
        bus(1, 8'h0C, 32'h0000_01FF, 7'h00);
        wbSel <= 4'h3;
        bus(0, 8'h0C, 32'h0000_0000, 7'h3E);
        bus(0, 8'h10, 32'h0000_0000, 7'h3E);
        bus(0, 8'h04, 32'h0000_0000, 7'h3E);
        $display("test startup done");
        bus(1, 8'h0C, 32'h0000_0002, 7'h00);
        cmp.fltBelowOtp <= 1'b1;
        cmp.fltAboveRec <= 1'b0;
        w(1300);
        bus(0, 8'h04, 32'h0000_0002, 7'h4A);
        bus(1, 8'h08, 32'h0000_0002, 7'h00);
        bus(0, 8'h08, 32'h0000_0000, 7'h0A);
        cmp.fltBelowOtp <= 1'b0;
        cmp.fltAboveRec <= 1'b1;
        w(20);
        bus(0, 8'h04, 32'h0000_0000, 7'h3E);
        $display("test overtemperature done");
        cmp.fltAboveOvp <= 1'b1;
        w(200 + $urandom % 900);
        cmp.fltAboveOvp <= 1'b0;
        w(20);
        bus(0, 8'h04, 32'h0000_0000, 7'h3E);
        $display("test glitch done");
        cmp.fbAboveHardOvp <= 1'b1;
        cmp.fbAboveSoftOvp <= 1'b1;
        cmp.fbBelowOvpRec <= 1'b0;
        w(10);
        bus(0, 8'h04, 32'h0000_0180, 7'h1E);
        cmp.fbAboveHardOvp <= 1'b0;
        cmp.fbAboveSoftOvp <= 1'b0;
        cmp.fbBelowOvpRec <= 1'b1;
        w(10);
        bus(0, 8'h04, 32'h0000_0000, 7'h3E);
        $display("test overvoltage done");
        cmp.fltAboveOvp <= 1'b1;
        w(1300);
        cmp.fltAboveOvp <= 1'b0;
        w(20);
        bus(0, 8'h04, 32'h0000_0001, 7'h0A);
        $display("test latch done");
        // Only a master reset frees the latch; read before regulation returns.
        resetn <= 1'b0;
        w(3);
        resetn <= 1'b1;
        bus(0, 8'h04, 32'h0000_0000, 7'h08);
        w(2000);
        bus(0, 8'h04, 32'h0000_0000, 7'h3E);
        $display("test reset done");
        // Undervoltage needs the hysteresis level; the bulk fault waits its timer.
        cmp.fbBelowUvp <= 1'b1;
        cmp.fbAboveUvpHys <= 1'b0;
        cmp.fbBelowBuv <= 1'b1;
        w(10);
        cmp.fbBelowUvp <= 1'b0;
        cmp.fbBelowBuv <= 1'b0;
        w(10);
        bus(0, 8'h04, 32'h0000_0060, 7'h0A);
        cmp.fbAboveUvpHys <= 1'b1;
        w(500);
        bus(0, 8'h04, 32'h0000_0000, 7'h3E);
        $display("test feedback done");
        // Sag then brownout; downstream ok falls only with static overvoltage.
        cmp.lineBelowStop <= 1'b1;
        cmp.lineAboveStart <= 1'b0;
        w(400);
        bus(0, 8'h04, 32'h0000_000C, 7'h07);
        cmp.static_overvoltage <= 1'b1;
        w(10);
        bus(0, 8'h04, 32'h0000_000C, 7'h03);
        cmp.lineBelowStop <= 1'b0;
        cmp.lineAboveStart <= 1'b1;
        cmp.static_overvoltage <= 1'b0;
        w(20);
        bus(0, 8'h04, 32'h0000_0000, 7'h3E);
        $display("test line done");
        test_done();
    end
endmodule : tb_top
